// *** hdl/mrci_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef MRCI_MAP_SVH
`define MRCI_MAP_SVH
// Register byte offsets
`define MRCI_OFS_CTRL 8'h00
`define MRCI_OFS_CHAN 8'h04
`define MRCI_OFS_STAT 8'h08
`define MRCI_OFS_TX 8'h0c
`define MRCI_OFS_RX 8'h10
// Control register fields
`define MRCI_CTL_TONEDIS 0
`define MRCI_CTL_BEEP 1
`define MRCI_CTL_MUTE 2
`define MRCI_CTL_TALK 3
`define MRCI_CTL_DL 4
`define MRCI_CTL_LATCH 5
`define MRCI_CTL_STORE 6
`define MRCI_CTL_RST 7
`define MRCI_CTL_DIRTX 8
`define MRCI_CTL_W 9
`define MRCI_CTL_RESET 9'h000
`define MRCI_CHAN_RESET 4'h0
// Status register fields
`define MRCI_ST_EMERG 4
`define MRCI_ST_RXRDY 10
// Core-side synchroniser bit positions
`define MRCI_SY_HOOK 0
`define MRCI_SY_CAS 1
`define MRCI_SY_LTONE 2
`define MRCI_SY_MIC 3
`define MRCI_SY_EMERG 4
`define MRCI_SY_OC 5
`define MRCI_SY_CH4 9
`define MRCI_SY_CHG 10
`define MRCI_SY_TVAL 11
`define MRCI_SY_RXTOG 12
`define MRCI_SY_W 13
// Lanes whose pins idle high: hook, mic, emergency, open-collector wires, line 4
`define MRCI_SY_IDLE 13'h03f9
// Radio reset pulse around each download
`define MRCI_CLK_NS 50
`define MRCI_RST_PULSE_NS 10000
`define MRCI_RST_CYC ((`MRCI_RST_PULSE_NS + `MRCI_CLK_NS - 1) / `MRCI_CLK_NS)
`endif

// *** hdl/mrci_pkg.sv ***
// Types shared by the radio control interface
package mrci_pkg;
    typedef enum logic [0:0] {
        MRCI_LK_IDLE = 1'b0,
        MRCI_LK_SHIFT = 1'b1
    } mrci_lkst_t;
    typedef struct packed {
        logic [8:0] ctrl;
        logic [3:0] chan;
        logic [7:0] txByte;
        logic txTog;
        logic [7:0] rxByte;
        logic rxTogSeen;
        logic emerg;
        logic rxRdy;
        logic [31:0] prdata;
        logic err;
        logic [7:0] rstCnt;
        logic dlPrev;
        logic toneDis;
        logic sqBypass;
        logic mute;
        logic talk;
        logic ltone;
        logic ch4;
        logic chg;
        logic store;
        logic radioRst;
    } mrci_core_t;
    typedef struct packed {
        mrci_lkst_t st;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic txSeen;
        logic rxTog;
        logic [7:0] rxByte;
        logic dout;
    } mrci_link_t;
endpackage

// *** hdl/mrci_sync.sv ***
// Two-stage level synchroniser, one stage pair per bit
`timescale 1ns/100ps
module mrci_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import mrci_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mrci_sy_t;
    mrci_sy_t s_r;
    mrci_sy_t s_nxt;
    // Per-bit stage pair; the first stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            s_nxt.s1[i] = d[i];
            s_nxt.s2[i] = s_r.s1[i];
        end
    end
    // Register the stages; reset shows each pin at its idle level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= {IDLE, IDLE};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r.s2;
endmodule // mrci_sync

// *** hdl/mrci_top.sv ***
// Mobile radio control interface: APB registers, pin logic, download link
// How it works
// - Hookswitch low turns off tone-squelch decoding gating reception.
// - Hookswitch inactive: speaker opens only with valid decoded tone.
// - Carrier-squelch low keeps received audio off the speaker.
// - Carrier-squelch inactive lets received audio reach the speaker when hookswitch low or tone valid.
// - Limited tone-squelch input is passed through to the processor.
// - Open-collector low tone-decode disable; radio then stops decoding.
// - Open-collector low squelch bypass during volume beeps.
// - Open-collector low mute; radio then mutes speaker audio.
// - Mute also tells the repeater a correct tone is heard.
// - Microphone talk request low starts a transmission.
// - Emergency request low starts an emergency signalling transmission.
// - Open-collector low radio talk output starts RF transmission.
// - Five active-low channel-select lines pick the channel.
// - Lines 0-3 from a register; line 4 and strobe buffered.
// - Channel-change strobe active high, asks radio to retune.
// - Download: tone disable latches, line 4 data, strobe clocks.
// - Store strobe output; radio reset pulsed before and after download.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "mrci_map.svh"
module mrci_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic linkClk,
    input wire logic hookswitch_in_n,
    input wire logic carrier_squelch_n,
    input wire logic limited_tone_squelch_in,
    output logic limitedToneToProc,
    input wire logic procToneValid,
    input wire logic mic_talk_request_n,
    input wire logic emergency_signal_request_n,
    input wire logic procChanSel4N,
    input wire logic procChanChange,
    input wire logic tone_decode_disable_out_n_in,
    output logic tone_decode_disable_out_n_out,
    output logic tone_decode_disable_out_n_oe,
    input wire logic noise_squelch_bypass_n_in,
    output logic noise_squelch_bypass_n_out,
    output logic noise_squelch_bypass_n_oe,
    input wire logic radio_mute_n_in,
    output logic radio_mute_n_out,
    output logic radio_mute_n_oe,
    input wire logic radio_talk_out_n_in,
    output logic radio_talk_out_n_out,
    output logic radio_talk_out_n_oe,
    output logic chan_sel_0_n,
    output logic chan_sel_1_n,
    output logic chan_sel_2_n,
    output logic chan_sel_3_n,
    input wire logic chan_sel_4_n_in,
    output logic chan_sel_4_n_out,
    output logic chan_sel_4_n_oe,
    output logic chan_change_strobe,
    output logic radioStore,
    output logic radioReset
);
    import mrci_pkg::*;
    mrci_core_t c_r;
    mrci_core_t c_nxt;
    mrci_link_t l_r;
    mrci_link_t l_nxt;
    logic [`MRCI_SY_W-1:0] syIn;
    logic [`MRCI_SY_W-1:0] syQ;
    logic [2:0] lkQ;
    logic hookS;
    logic casS;
    logic micS;
    logic emergS;
    logic tvalS;
    logic dl;
    logic wrAcc;
    logic rdSet;
    logic spkOpen;

    // Pin inputs and link toggle into the core domain
    assign syIn = {l_r.rxTog, procToneValid, procChanChange, procChanSel4N,
        radio_talk_out_n_in, radio_mute_n_in, noise_squelch_bypass_n_in,
        tone_decode_disable_out_n_in, emergency_signal_request_n,
        mic_talk_request_n, limited_tone_squelch_in, carrier_squelch_n,
        hookswitch_in_n};
    // Stages reset to each pin's idle level so no false event follows reset
    mrci_sync #(.W(`MRCI_SY_W), .IDLE(`MRCI_SY_IDLE)) u_sync_core (
        .clk(core_clk),
        .rst(rst),
        .ce(ce),
        .d(syIn),
        .q(syQ)
    );
    // Core controls into the link domain
    mrci_sync #(.W(3)) u_sync_link (
        .clk(linkClk),
        .rst(rst),
        .ce(1'b1),
        .d({c_r.txTog, c_r.ctrl[`MRCI_CTL_DIRTX], c_r.ctrl[`MRCI_CTL_DL]}),
        .q(lkQ)
    );

    // Decoded inputs and bus strobes
    assign hookS = syQ[`MRCI_SY_HOOK];
    assign casS = syQ[`MRCI_SY_CAS];
    assign micS = syQ[`MRCI_SY_MIC];
    assign emergS = syQ[`MRCI_SY_EMERG];
    assign tvalS = syQ[`MRCI_SY_TVAL];
    assign dl = c_r.ctrl[`MRCI_CTL_DL];
    assign wrAcc = psel & penable & pwrite;
    assign rdSet = psel & ~penable & ~pwrite;
    // Speaker gate: carrier present, and tone valid unless monitoring
    assign spkOpen = casS & (~hookS | tvalS);

    // Core next state: registers, pin drivers, reset pulse
    always_comb begin
        c_nxt = c_r;
        c_nxt.err = 1'b0;
        if (psel & ~penable) begin
            c_nxt.err = ~(paddr inside {`MRCI_OFS_CTRL, `MRCI_OFS_CHAN,
                `MRCI_OFS_STAT, `MRCI_OFS_TX, `MRCI_OFS_RX});
        end
        if (wrAcc) begin
            unique case (paddr)
                `MRCI_OFS_CTRL: begin
                    c_nxt.ctrl = pwdata[`MRCI_CTL_W-1:0];
                end
                `MRCI_OFS_CHAN: begin
                    c_nxt.chan = pwdata[3:0];
                end
                `MRCI_OFS_STAT: begin
                    if (pwdata[`MRCI_ST_EMERG]) begin
                        c_nxt.emerg = 1'b0;
                    end
                    if (pwdata[`MRCI_ST_RXRDY]) begin
                        c_nxt.rxRdy = 1'b0;
                    end
                end
                `MRCI_OFS_TX: begin
                    c_nxt.txByte = pwdata[7:0];
                    c_nxt.txTog = ~c_r.txTog;
                end
                default: begin
                end
            endcase
        end
        // Sticky events; a set beats a same-cycle clear
        if (~emergS) begin
            c_nxt.emerg = 1'b1;
        end
        if (syQ[`MRCI_SY_RXTOG] != c_r.rxTogSeen) begin
            c_nxt.rxTogSeen = syQ[`MRCI_SY_RXTOG];
            c_nxt.rxByte = l_r.rxByte;
            c_nxt.rxRdy = 1'b1;
        end
        // Read data captured in the setup cycle
        if (rdSet) begin
            unique case (paddr)
                `MRCI_OFS_CTRL: c_nxt.prdata = {23'h000000, c_r.ctrl};
                `MRCI_OFS_CHAN: c_nxt.prdata = {28'h0000000, c_r.chan};
                `MRCI_OFS_STAT: c_nxt.prdata = {21'h000000, c_r.rxRdy,
                    dl, syQ[`MRCI_SY_OC+3:`MRCI_SY_OC], c_r.emerg,
                    syQ[`MRCI_SY_MIC:`MRCI_SY_HOOK]};
                `MRCI_OFS_TX: c_nxt.prdata = {24'h000000, c_r.txByte};
                `MRCI_OFS_RX: c_nxt.prdata = {24'h000000, c_r.rxByte};
                default: c_nxt.prdata = 32'h00000000;
            endcase
        end
        // Radio reset on entry to and exit from download
        c_nxt.dlPrev = dl;
        if (dl != c_r.dlPrev) begin
            c_nxt.rstCnt = 8'(`MRCI_RST_CYC);
        end else if (c_r.rstCnt != 8'h00) begin
            c_nxt.rstCnt = c_r.rstCnt - 8'h01;
        end
        c_nxt.radioRst = c_r.ctrl[`MRCI_CTL_RST] | (c_nxt.rstCnt != 8'h00);
        c_nxt.store = c_r.ctrl[`MRCI_CTL_STORE];
        // Open-collector assert levels
        c_nxt.toneDis = dl ? c_r.ctrl[`MRCI_CTL_LATCH]
            : (~hookS | c_r.ctrl[`MRCI_CTL_TONEDIS]);
        c_nxt.sqBypass = c_r.ctrl[`MRCI_CTL_BEEP];
        c_nxt.mute = ~spkOpen | c_r.ctrl[`MRCI_CTL_MUTE];
        c_nxt.talk = ~dl & (~micS | c_r.emerg | ~emergS
            | c_r.ctrl[`MRCI_CTL_TALK]);
        c_nxt.ltone = syQ[`MRCI_SY_LTONE];
        c_nxt.ch4 = syQ[`MRCI_SY_CH4];
        c_nxt.chg = syQ[`MRCI_SY_CHG];
    end

    // Core state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            c_r <= '0;
        end else if (ce) begin
            c_r <= c_nxt;
        end
    end

    // Link domain: shift a byte out or in on each rising serial clock edge
    always_comb begin
        l_nxt = l_r;
        unique case (l_r.st)
            MRCI_LK_IDLE: begin
                if (lkQ[0] && lkQ[2] != l_r.txSeen) begin
                    l_nxt.txSeen = lkQ[2];
                    l_nxt.sh = c_r.txByte;
                    l_nxt.cnt = 3'h7;
                    l_nxt.st = MRCI_LK_SHIFT;
                    l_nxt.dout = c_r.txByte[7];
                end
            end
            MRCI_LK_SHIFT: begin
                // Line 4 input is synchronous to the serial clock
                l_nxt.sh = {l_r.sh[6:0], chan_sel_4_n_in};
                l_nxt.dout = l_r.sh[6];
                l_nxt.cnt = l_r.cnt - 3'h1;
                if (l_r.cnt == 3'h0 || !lkQ[0]) begin
                    l_nxt.st = MRCI_LK_IDLE;
                    if (!lkQ[1]) begin
                        l_nxt.rxByte = {l_r.sh[6:0], chan_sel_4_n_in};
                        l_nxt.rxTog = ~l_r.rxTog;
                    end
                end
            end
        endcase
    end

    // Link state register
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Open-collector pins pull low or float
    assign tone_decode_disable_out_n_out = 1'b0;
    assign tone_decode_disable_out_n_oe = c_r.toneDis;
    assign noise_squelch_bypass_n_out = 1'b0;
    assign noise_squelch_bypass_n_oe = c_r.sqBypass;
    assign radio_mute_n_out = 1'b0;
    assign radio_mute_n_oe = c_r.mute;
    assign radio_talk_out_n_out = 1'b0;
    assign radio_talk_out_n_oe = c_r.talk;
    // Channel select, strobe and download pins
    assign chan_sel_0_n = ~c_r.chan[0];
    assign chan_sel_1_n = ~c_r.chan[1];
    assign chan_sel_2_n = ~c_r.chan[2];
    assign chan_sel_3_n = ~c_r.chan[3];
    assign chan_sel_4_n_out = dl ? l_r.dout : c_r.ch4;
    assign chan_sel_4_n_oe = ~dl | c_r.ctrl[`MRCI_CTL_DIRTX];
    assign chan_change_strobe = dl ? linkClk : c_r.chg;
    assign limitedToneToProc = c_r.ltone;
    assign radioStore = c_r.store;
    assign radioReset = c_r.radioRst;
    // APB answer: ready while enabled, error on unmapped address
    assign prdata = c_r.prdata;
    assign pready = ce;
    assign pslverr = psel & penable & c_r.err;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_chanWrite;
        wrAcc && ce && paddr == `MRCI_OFS_CHAN;
    endsequence
    sequence s_dlToggle;
        ce && dl != c_r.dlPrev;
    endsequence
    sequence s_pinSteady;
        ce && !dl && !wrAcc;
    endsequence

    a_carrier_mute: assert property (
        ce && !casS |=> radio_mute_n_oe)
        else $error("mute not asserted without carrier");
    a_tone_gate: assert property (
        ce && hookS && casS && !tvalS |=> radio_mute_n_oe)
        else $error("speaker opened without valid tone");
    a_speaker_open: assert property (
        ce && casS && tvalS && !c_r.ctrl[`MRCI_CTL_MUTE] |=> !radio_mute_n_oe)
        else $error("speaker held muted with carrier and tone");
    a_hook_decode: assert property (
        ce && !hookS && !dl |=> tone_decode_disable_out_n_oe)
        else $error("tone decode not disabled on hookswitch");
    a_mic_talk: assert property (
        ce && !micS && !dl |=> radio_talk_out_n_oe)
        else $error("talk request not passed to radio");
    a_emerg_talk: assert property (
        ce && $fell(emergS) && !dl |=> ##[0:1] radio_talk_out_n_oe && c_r.emerg)
        else $error("emergency request lost");
    a_oc_low: assert property (
        !(tone_decode_disable_out_n_out | radio_mute_n_out
        | noise_squelch_bypass_n_out | radio_talk_out_n_out))
        else $error("open-collector output driven high");
    a_chan_write: assert property (
        s_chanWrite |=> ##1 chan_sel_0_n == ~$past(pwdata[0], 2))
        else $error("channel select does not follow register");
    a_dl_reset: assert property (
        s_dlToggle |=> radioReset [*8])
        else $error("radio reset missing around download");
    a_data_release: assert property (
        dl && !c_r.ctrl[`MRCI_CTL_DIRTX] |-> !chan_sel_4_n_oe)
        else $error("data line driven while radio drives");

    // Registered drivers follow their sources one enabled edge later
    a_tone_pass: assert property (
        ce |=> limitedToneToProc == $past(syQ[`MRCI_SY_LTONE]))
        else $error("tone input not passed to processor");
    a_beep_bypass: assert property (
        ce |=> noise_squelch_bypass_n_oe == $past(c_r.ctrl[`MRCI_CTL_BEEP]))
        else $error("squelch bypass does not follow beep control");
    a_store_follow: assert property (
        ce |=> radioStore == $past(c_r.ctrl[`MRCI_CTL_STORE]))
        else $error("store strobe does not follow control");
    a_line4_buffer: assert property (
        s_pinSteady |=> chan_sel_4_n_out == $past(syQ[`MRCI_SY_CH4]))
        else $error("channel line 4 not buffered");
    a_change_buffer: assert property (
        s_pinSteady |=> chan_change_strobe == $past(syQ[`MRCI_SY_CHG]))
        else $error("channel change strobe not buffered");

    // Download mode: line roles and received bytes
    a_latch_line: assert property (
        ce && dl |=> tone_decode_disable_out_n_oe == $past(c_r.ctrl[`MRCI_CTL_LATCH]))
        else $error("latch line does not follow control");
    a_dl_no_talk: assert property (
        ce && dl |=> !radio_talk_out_n_oe)
        else $error("radio keyed during download");
    a_rx_flag: assert property (
        ce && syQ[`MRCI_SY_RXTOG] != c_r.rxTogSeen |=> c_r.rxRdy)
        else $error("received byte not flagged");
endmodule // mrci_top

// *** verification/mrci_radio_model.sv ***
// Behavioural mobile radio and repeater on the far side of the control pins
`timescale 1ns/100ps
module mrci_radio_model (
    input wire logic strobe,
    input wire logic armed,
    input wire logic [7:0] sendByte,
    input wire logic toneWire,
    input wire logic bypWire,
    input wire logic muteWire,
    input wire logic talkWire,
    output logic dataLvl,
    output logic dataOe,
    output logic decodeOff,
    output logic sqOpen,
    output logic muted,
    output logic keyed
);
    int k;
    logic bitV;
    // Radio and repeater reactions to the pulled-low lines
    assign decodeOff = !toneWire;
    assign sqOpen = !bypWire;
    assign muted = !muteWire;
    assign keyed = !talkWire;
    // Count clock edges of one framed byte
    always @(posedge strobe or negedge armed) begin
        if (!armed) begin
            k <= 0;
        end else begin
            k <= k + 1;
        end
    end
    // Next bit set up on the falling edge, MSB first
    always @(posedge armed or negedge strobe) begin
        if (k < 4) begin
            bitV <= sendByte[7];
        end else if (k < 11) begin
            bitV <= sendByte[10-k];
        end
    end
    // Drives only within its byte; released line shows a changed level
    assign dataOe = armed && (k < 11);
    assign dataLvl = dataOe ? bitV : ~bitV;
endmodule // mrci_radio_model

// *** verification/tb_mobile_radio_control_interface.sv ***
// Self-checking bench for the mobile radio control interface
`timescale 1ns/100ps
`include "mrci_map.svh"
module tb_mobile_radio_control_interface;
    logic core_clk, rst, ce, psel, penable, pwrite, pready, pslverr, linkClk, err;
    logic [7:0] paddr, sendByte;
    logic [31:0] pwdata, prdata, rd;
    logic hookswitch_in_n, carrier_squelch_n, limited_tone_squelch_in, limitedToneToProc;
    logic procToneValid, mic_talk_request_n, emergency_signal_request_n, procChanSel4N;
    logic procChanChange, toneOut, toneOe, bypOut, bypOe, muteOut, muteOe, talkOut, talkOe;
    logic chan_sel_0_n, chan_sel_1_n, chan_sel_2_n, chan_sel_3_n, ch4Out, ch4Oe;
    logic chan_change_strobe, radioStore, radioReset, radioLvl, radioOe, armed, keyed, muted;
    logic toneWire, bypWire, muteWire, talkWire, ch4Wire;
    int nErrors, samplesChecked, cycles;
    // Pulled-up open-collector lines; line 4 shared with the radio
    assign toneWire = toneOe ? toneOut : 1'b1;
    assign bypWire = bypOe ? bypOut : 1'b1;
    assign muteWire = muteOe ? muteOut : 1'b1;
    assign talkWire = talkOe ? talkOut : 1'b1;
    assign ch4Wire = ch4Oe ? ch4Out : radioLvl;
    mrci_top dut (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .linkClk(linkClk), .hookswitch_in_n(hookswitch_in_n),
        .carrier_squelch_n(carrier_squelch_n), .limitedToneToProc(limitedToneToProc),
        .limited_tone_squelch_in(limited_tone_squelch_in), .procToneValid(procToneValid),
        .mic_talk_request_n(mic_talk_request_n), .procChanSel4N(procChanSel4N),
        .emergency_signal_request_n(emergency_signal_request_n), .procChanChange(procChanChange),
        .tone_decode_disable_out_n_in(toneWire), .tone_decode_disable_out_n_out(toneOut),
        .tone_decode_disable_out_n_oe(toneOe), .noise_squelch_bypass_n_in(bypWire),
        .noise_squelch_bypass_n_out(bypOut), .noise_squelch_bypass_n_oe(bypOe),
        .radio_mute_n_in(muteWire), .radio_mute_n_out(muteOut), .radio_mute_n_oe(muteOe),
        .radio_talk_out_n_in(talkWire), .radio_talk_out_n_out(talkOut),
        .radio_talk_out_n_oe(talkOe), .chan_sel_0_n(chan_sel_0_n), .chan_sel_1_n(chan_sel_1_n),
        .chan_sel_2_n(chan_sel_2_n), .chan_sel_3_n(chan_sel_3_n), .chan_sel_4_n_in(ch4Wire),
        .chan_sel_4_n_out(ch4Out), .chan_sel_4_n_oe(ch4Oe),
        .chan_change_strobe(chan_change_strobe), .radioStore(radioStore),
        .radioReset(radioReset));
    mrci_radio_model radio (.strobe(chan_change_strobe), .armed(armed), .sendByte(sendByte),
        .toneWire(toneWire), .bypWire(bypWire), .muteWire(muteWire), .talkWire(talkWire),
        .dataLvl(radioLvl), .dataOe(radioOe), .decodeOff(), .sqOpen(), .muted(muted),
        .keyed(keyed));
    // Core clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            $display("[ERR] %0t timeout", $time);
            endOfTest();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One APB transfer; read data and error kept in rd and err
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One framed byte of link clocks, 80 ns period, free phase
    task automatic burst(input logic [7:0] b, input logic look);
        #13;
        for (int k = 0; k < 11; k++) begin
            linkClk = 1'b1;
            #40;
            if (k == 4) chk(chan_change_strobe, 1'b1, "clock on strobe");
            linkClk = 1'b0;
            if (look && k >= 2 && k <= 9) chk(ch4Out, b[9-k], "tx bit");
            #40;
        end
    endtask
    task automatic endOfTest;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst, ce, hookswitch_in_n, carrier_squelch_n, mic_talk_request_n} = 5'h1f;
        {emergency_signal_request_n, procChanSel4N, procToneValid} = 3'h7;
        {psel, penable, pwrite, paddr, pwdata, linkClk, armed} = '0;
        {limited_tone_squelch_in, procChanChange} = 2'h0;
        sendByte = 8'h3c;
        #30 linkClk = 1'b1;
        #40 linkClk = 1'b0;
        cyc(5);
        chk({toneOe, bypOe, muteOe, talkOe, ch4Oe}, 5'h01, "reset enables");
        chk({chan_sel_3_n, chan_sel_2_n, chan_sel_1_n, chan_sel_0_n}, 4'hf, "reset chan");
        chk({radioReset, radioStore}, 2'h0, "reset strobes");
        cyc(1);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `MRCI_OFS_CHAN, i);
            cyc(2);
            chk({chan_sel_3_n, chan_sel_2_n, chan_sel_1_n, chan_sel_0_n}, {~i[3:0]}, "chan");
            apb(1'b0, `MRCI_OFS_CHAN, 32'h0);
            chk(rd, i, "chan read");
        end
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        @(posedge core_clk);
        procChanSel4N <= 1'b0;
        procChanChange <= 1'b1;
        cyc(4);
        chk({ch4Out, ch4Oe, chan_change_strobe}, 3'h3, "buffered lines");
        procChanSel4N <= 1'b1;
        procChanChange <= 1'b0;
        cyc(4);
        chk({ch4Out, chan_change_strobe}, 2'h2, "buffered idle");
        $display("channel test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            {hookswitch_in_n, carrier_squelch_n, procToneValid} <= i[2:0];
            limited_tone_squelch_in <= i[0];
            cyc(4);
            chk(muteOe, !(i[1] && (!i[2] || i[0])), "mute");
            chk(toneOe, !i[2], "tone decode off");
            chk(limitedToneToProc, i[0], "tone pass");
        end
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, `MRCI_OFS_CTRL, 32'h1 << j);
            cyc(2);
            chk({talkOe, muteOe, bypOe, toneOe}, 4'h1 << j, "forced lines");
            chk({toneOut, bypOut, muteOut, talkOut}, 4'h0, "low only");
            chk({keyed, muted}, {j == 3, j == 2}, "radio reacts");
        end
        apb(1'b1, `MRCI_OFS_CTRL, 32'h0);
        @(posedge core_clk);
        mic_talk_request_n <= 1'b0;
        cyc(4);
        chk(talkOe, 1'b1, "mic talk");
        mic_talk_request_n <= 1'b1;
        emergency_signal_request_n <= 1'b0;
        cyc(4);
        emergency_signal_request_n <= 1'b1;
        cyc(4);
        apb(1'b0, `MRCI_OFS_STAT, 32'h0);
        chk({talkOe, rd[4]}, 2'h3, "emergency held");
        apb(1'b1, `MRCI_OFS_STAT, 32'h10);
        cyc(2);
        chk(talkOe, 1'b0, "emergency cleared");
        ce <= 1'b0;
        mic_talk_request_n <= 1'b0;
        cyc(4);
        chk({pready, talkOe}, 2'h0, "frozen while disabled");
        ce <= 1'b1;
        mic_talk_request_n <= 1'b1;
        cyc(4);
        $display("pin test done");
        apb(1'b1, `MRCI_OFS_CTRL, 32'h40);
        cyc(2);
        chk(radioStore, 1'b1, "store");
        apb(1'b1, `MRCI_OFS_CTRL, 32'h80);
        cyc(2);
        chk({radioReset, radioStore}, 2'h2, "forced reset");
        apb(1'b1, `MRCI_OFS_CTRL, 32'h130);
        cyc(3);
        chk({radioReset, toneOe, talkOe}, 3'h6, "download entry");
        cyc(`MRCI_RST_CYC + 5);
        chk(radioReset, 1'b0, "reset pulse end");
        apb(1'b1, `MRCI_OFS_TX, 32'ha5);
        burst(8'ha5, 1'b1);
        apb(1'b1, `MRCI_OFS_CTRL, 32'h30);
        cyc(2);
        chk(ch4Oe, 1'b0, "line released");
        armed <= 1'b1;
        apb(1'b1, `MRCI_OFS_TX, 32'h0);
        burst(8'h0, 1'b0);
        armed <= 1'b0;
        cyc(6);
        apb(1'b0, `MRCI_OFS_STAT, 32'h0);
        chk(rd[10], 1'b1, "rx ready");
        apb(1'b0, `MRCI_OFS_RX, 32'h0);
        chk(rd, 32'h3c, "rx byte");
        apb(1'b1, `MRCI_OFS_CTRL, 32'h0);
        cyc(3);
        chk(radioReset, 1'b1, "reset after download");
        $display("download test done");
        endOfTest();
    end
endmodule // tb_mobile_radio_control_interface
